// File: sdr_pkg.sv
// Shared constants, types and response-layout functions for the squib diagnostic read-back block.
package sdr_pkg;

  // Command codes decoded by the read-back logic.
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_CNT_A1   = 8'h70;
  localparam logic [7:0] CMD_CNT_B1   = 8'h71;
  localparam logic [7:0] CMD_CNT_A2   = 8'h72;
  localparam logic [7:0] CMD_CNT_B2   = 8'h73;
  localparam logic [7:0] CMD_CLIM     = 8'h79;
  localparam logic [7:0] CMD_THERM    = 8'h7F;
  localparam logic [7:0] CMD_SAFE     = 8'hC0;
  localparam logic [7:0] CMD_SHORT    = 8'hC1;
  localparam logic [7:0] CMD_LOW_SIDE_CONTINUITY_FLAG     = 8'hC2;
  localparam logic [7:0] CMD_OPEN     = 8'hC3;
  localparam logic [7:0] CMD_FIRE_SUPPLY    = 8'hC5;
  localparam logic [7:0] CMD_VDLVL    = 8'hC6;
  localparam logic [7:0] CMD_ARM_FIRST = 8'hA0;
  localparam logic [7:0] CMD_ARM_LAST  = 8'hA2;
  localparam logic [3:0] CMD_FIRE_HI  = 4'h5;

  // Frame and reset values.
  localparam int         FRAME_BITS = 8;
  localparam logic [3:0] FRAME_CNT  = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] RESP_RST   = 8'h00;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;

  // Measurement timebase: one count per tick.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MEAS_TICK_NS  = 1000;
  localparam int MEAS_TICK_CYC = (MEAS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Channel index order: 0 = a1, 1 = b1, 2 = a2, 3 = b2; pair index 0 = pair 1.
  typedef struct packed {
    logic [3:0] cur_limit;
    logic [3:0] low_side_thermal_flag;
    logic [3:0] high_side_thermal_flag;
    logic [1:0] safing_res_low_flag;
    logic [1:0] safing_res_high_flag;
    logic [1:0] diag_supply_high_flag;
    logic [1:0] diag_supply_low_flag;
    logic [3:0] no_short_ground_flag;
    logic [3:0] no_short_battery_flag;
    logic [3:0] low_side_continuity_flag;
    logic [3:0] open_no_short_ground_flag;
    logic [3:0] open_no_short_battery_flag;
    logic       fire_supply_b_tested;
    logic       fire_supply_high_flag;
    logic       fire_supply_low_flag;
    logic [3:0] diag_supply1_level;
    logic [3:0] diag_supply2_level;
  } sdr_diag_t;

  typedef logic [3:0][7:0] sdr_counts_t;

  // Interleave per-channel flag pairs, channel b2 at the top, upper flag first.
  function automatic logic [7:0] sdr_pairs(input logic [3:0] upper, input logic [3:0] lower);
    sdr_pairs = {upper[3], lower[3], upper[2], lower[2], upper[1], lower[1], upper[0], lower[0]};
  endfunction : sdr_pairs

  // Arm or fire commands are echoed back unchanged.
  function automatic logic sdr_is_echo(input logic [7:0] cmd);
    sdr_is_echo = ((cmd >= CMD_ARM_FIRST) && (cmd <= CMD_ARM_LAST)) || (cmd[7:4] == CMD_FIRE_HI);
  endfunction : sdr_is_echo

  function automatic logic sdr_is_arm(input logic [7:0] cmd);
    sdr_is_arm = (cmd >= CMD_ARM_FIRST) && (cmd <= CMD_ARM_LAST);
  endfunction : sdr_is_arm

endpackage : sdr_pkg

// File: sdr_curr_cnt.sv
// Per-channel saturating current measurement time counter.
`timescale 1ns/1ps
module sdr_curr_cnt
  import sdr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       above_i,
  input  wire logic       clr_i,
  output logic [7:0]      count_o
);

  logic [7:0] count_reg;

  // count while timed above threshold
  // Saturation keeps a long pulse from wrapping into a short-looking reading.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= CNT_RST;
    end else if (clr_i) begin
      count_reg <= CNT_RST;
    end else if (tick_i && run_i && above_i && (count_reg != CNT_MAX)) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  assign count_o = count_reg;

  a_count_advance: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (tick_i && run_i && above_i && !clr_i && count_reg != CNT_MAX) |=> count_reg == $past(count_reg) + 8'h01)
    else $error("counter did not advance");
  a_count_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!clr_i && !(tick_i && run_i && above_i)) |=> $stable(count_reg))
    else $error("counter moved without cause");
  a_count_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_i |=> count_reg == CNT_RST)
    else $error("counter not cleared");

endmodule : sdr_curr_cnt

// File: sdr_readback.sv
// Serial command decoder returning diagnostic status bytes on the following transfer.
//
// Overview of operation
// - The byte for a command is sent during the next transfer, so the host sends another command to fetch it.
// - The no-operation command does nothing and yields an all-zero byte.
// - Codes 70 to 73 return the 8-bit current time count of channels a1, b1, a2, b2, MSB in bit 7.
// - Code 79 returns zero in bits 7..4 and current-limit flags of b2, a2, b1, a1 in bits 3..0.
// - Code 7F returns low-side then high-side thermal flags per channel, b2 pair at the top.
// - Code C0 returns pair 2 high and pair 1 low, each as safing low, safing high, supply high, supply low.
// - Code C1 returns no-short-to-ground over no-short-to-battery per channel, b2 pair at the top.
// - Code C2 returns zero in bits 7..4 and low-side continuity of b2, a2, b1, a1 in bits 3..0.
// - Code C3 returns the open-squib harness short flags in the same pair layout as C1.
// - Code C5 returns zeros in 7..5, supply-B tested in 4, zeros for don't-care 3..2, high in 1, low in 0.
// - Code C6 returns diagnostic supply 2 levels in 7..4 and supply 1 levels in 3..0, highest first.
// - Each channel count advances while its timer runs and the current is above threshold.
// - An arming command clears the four current time counts and pulses diag_clear_o; the diag_i flags are not cleared here.
// - Each command is exactly one 8-bit transfer, and arm and fire commands are echoed.
`timescale 1ns/1ps
module sdr_readback
  import sdr_pkg::*;
#(
  parameter int TICK_CYC = MEAS_TICK_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire sdr_diag_t  diag_i,
  input  wire logic [3:0] meas_run_i,
  input  wire logic [3:0] cur_above_i,
  output logic            miso_o,
  output logic            cmd_done_o,
  output logic [7:0]      cmd_byte_o,
  output logic            diag_clear_o
);

  logic        sclk_reg;
  logic        cs_n_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  resp_reg;
  logic [7:0]  resp_next;
  logic [15:0] tick_cnt_reg;
  logic        tick_reg;
  sdr_counts_t counts;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_done;
  logic        arm_done;

  // Edge detection on the port lines, which arrive synchronous to the system clock.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk_i;
      cs_n_reg <= cs_n_i;
    end
  end

  assign cs_fall   = cs_n_reg && !cs_n_i;
  assign cs_rise   = !cs_n_reg && cs_n_i;
  assign sclk_rise = !sclk_reg && sclk_i && !cs_n_i;
  assign sclk_fall = sclk_reg && !sclk_i && !cs_n_i;
  assign frame_done = cs_rise && (bit_cnt_reg == FRAME_CNT);
  assign arm_done   = frame_done && sdr_is_arm(rx_reg);

  // Receive shifter; extra clocks beyond eight are ignored so a long frame cannot misalign the code.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= BIT_CNT_RST;
      rx_reg      <= RESP_RST;
    end else if (cs_fall) begin
      bit_cnt_reg <= BIT_CNT_RST;
    end else if (sclk_rise && (bit_cnt_reg < FRAME_CNT)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      rx_reg      <= {rx_reg[6:0], mosi_i};
    end
  end

  // MSB first, shifted on falling clock
  // the stored answer goes out in the next frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_reg <= RESP_RST;
      miso_o <= 1'b0;
    end else if (cs_fall) begin
      tx_reg <= resp_reg;
      miso_o <= resp_reg[7];
    end else if (sclk_fall && (bit_cnt_reg != BIT_CNT_RST) && (bit_cnt_reg < FRAME_CNT)) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      miso_o <= tx_reg[6];
    end
  end

  // Response layout for the command just received; unknown codes answer zero.
  always_comb begin
    resp_next = RESP_RST;
    if (sdr_is_echo(rx_reg)) begin
      resp_next = rx_reg;
    end else if (rx_reg == CMD_NOP) begin
      resp_next = RESP_RST;
    end else if ((rx_reg >= CMD_CNT_A1) && (rx_reg <= CMD_CNT_B2)) begin
      resp_next = counts[rx_reg[1:0]];
    end else if (rx_reg == CMD_CLIM) begin
      resp_next = {4'h0, diag_i.cur_limit};
    end else if (rx_reg == CMD_THERM) begin
      resp_next = sdr_pairs(diag_i.low_side_thermal_flag, diag_i.high_side_thermal_flag);
    end else if (rx_reg == CMD_SAFE) begin
      resp_next = {diag_i.safing_res_low_flag[1], diag_i.safing_res_high_flag[1],
                   diag_i.diag_supply_high_flag[1], diag_i.diag_supply_low_flag[1],
                   diag_i.safing_res_low_flag[0], diag_i.safing_res_high_flag[0],
                   diag_i.diag_supply_high_flag[0], diag_i.diag_supply_low_flag[0]};
    end else if (rx_reg == CMD_SHORT) begin
      resp_next = sdr_pairs(diag_i.no_short_ground_flag, diag_i.no_short_battery_flag);
    end else if (rx_reg == CMD_LOW_SIDE_CONTINUITY_FLAG) begin
      resp_next = {4'h0, diag_i.low_side_continuity_flag};
    end else if (rx_reg == CMD_OPEN) begin
      resp_next = sdr_pairs(diag_i.open_no_short_ground_flag, diag_i.open_no_short_battery_flag);
    end else if (rx_reg == CMD_FIRE_SUPPLY) begin
      // fire supply status, don't-care bits driven low
      resp_next = {3'b000, diag_i.fire_supply_b_tested, 2'b00,
                   diag_i.fire_supply_high_flag, diag_i.fire_supply_low_flag};
    end else if (rx_reg == CMD_VDLVL) begin
      resp_next = {diag_i.diag_supply2_level, diag_i.diag_supply1_level};
    end
  end

  // answer captured at the end of the command frame
  // Flags are sampled once here, so a flag changing mid-readout cannot tear the byte.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_reg   <= RESP_RST;
      cmd_byte_o <= RESP_RST;
    end else if (frame_done) begin
      resp_reg   <= resp_next;
      cmd_byte_o <= rx_reg;
    end
  end

  // Frame and clear strobes, one cycle each.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_done_o   <= 1'b0;
      diag_clear_o <= 1'b0;
    end else begin
      cmd_done_o   <= frame_done;
      diag_clear_o <= arm_done;
    end
  end

  // Measurement timebase divider producing a one-cycle tick.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  // One counter per channel, cleared by the arming command.
  for (genvar ch = 0; ch < 4; ch++) begin : g_cnt
    sdr_curr_cnt u_cnt (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (tick_reg),
      .run_i     (meas_run_i[ch]),
      .above_i   (cur_above_i[ch]),
      .clr_i     (arm_done),
      .count_o   (counts[ch])
    );
  end

  a_nop_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_NOP) |=> resp_reg == 8'h00)
    else $error("nop answer not zero");
  a_count_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_CNT_B1) |=> resp_reg == $past(counts[1]))
    else $error("count readout wrong");
  a_clim_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_CLIM) |=> resp_reg == {4'h0, $past(diag_i.cur_limit)})
    else $error("current limit layout wrong");
  a_therm_top: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_THERM) |=>
      resp_reg[7:6] == {$past(diag_i.low_side_thermal_flag[3]), $past(diag_i.high_side_thermal_flag[3])})
    else $error("thermal layout wrong");
  a_safe_nibble: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_SAFE) |=> resp_reg[3] == $past(diag_i.safing_res_low_flag[0]))
    else $error("safing layout wrong");
  a_short_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_SHORT) |=> resp_reg[1:0] ==
      {$past(diag_i.no_short_ground_flag[0]), $past(diag_i.no_short_battery_flag[0])})
    else $error("short layout wrong");
  a_fire_supply_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && rx_reg == CMD_FIRE_SUPPLY) |=> resp_reg[7:5] == 3'b000 && resp_reg[3:2] == 2'b00)
    else $error("fire supply fixed bits wrong");
  a_echo_arm: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && sdr_is_echo(rx_reg)) |=> resp_reg == $past(rx_reg))
    else $error("arm or fire not echoed");
  a_arm_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && sdr_is_arm(rx_reg)) |=> diag_clear_o && counts == '0)
    else $error("arm did not clear results");
  a_short_frame: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cs_rise && bit_cnt_reg != FRAME_CNT) |=> $stable(resp_reg) && !cmd_done_o)
    else $error("partial frame accepted");
  a_miso_msb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cs_fall |=> miso_o == $past(resp_reg[7]))
    else $error("first bit not msb");

  c_nop: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) frame_done && rx_reg == CMD_NOP);
  c_arm: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) arm_done);
  c_count: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    frame_done && rx_reg == CMD_CNT_A1 && counts[0] != CNT_RST);

endmodule : sdr_readback

// File: sdr_host_model.sv
// Host microcontroller model acting as a mode 0 serial master towards the read-back block.
`timescale 1ns/1ps
module sdr_host_model (
  input  wire logic clk_sys_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  // The serial clock stands low and the select stays high between frames.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame: nbits command bits out, the same number of answer bits in.
  // frames of nbits bits, at most eight
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] resp);
    resp = 8'h00;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    for (int k = 0; k < nbits; k++) begin
      @(posedge clk_sys_i);
      mosi_o <= cmd[7-k];
      repeat (2) @(posedge clk_sys_i);
      // Sampled mid-cycle so the answer bit has settled after the last falling edge.
      @(negedge clk_sys_i);
      resp[7-k] = miso_i;
      @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (3) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    // A deselected data line must not keep a value the design could lean on.
    mosi_o <= ~mosi_o;
    repeat (3) @(posedge clk_sys_i);
  endtask : xfer
endmodule : sdr_host_model

// File: tb.sv
// Self-checking testbench for the squib diagnostic read-back block.
`timescale 1ns/1ps
module tb;
  import sdr_pkg::*;
  `define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

  logic        clk_sys_i;
  logic        rst_n_i;
  logic        sclk, cs_n, mosi, miso_o, cmd_done_o, diag_clear_o;
  logic [7:0]  cmd_byte_o;
  sdr_diag_t   diag_i;
  logic [3:0]  meas_run_i;
  logic [3:0]  cur_above_i;
  logic [7:0]  cnt_exp [4];
  logic [7:0]  prev_exp;
  logic [7:0]  codes [16] = '{8'h00, 8'h70, 8'h71, 8'h72, 8'h73, 8'h79, 8'h7F, 8'hC0,
                               8'hC1, 8'hC2, 8'hC3, 8'hC5, 8'hC6, 8'hA1, 8'h5A, 8'h35};
  int          err_total, check_count, done_cnt, clr_cnt, cyc, seed;

  sdr_readback #(.TICK_CYC(4)) sdr_readback_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .diag_i(diag_i), .meas_run_i(meas_run_i), .cur_above_i(cur_above_i), .miso_o(miso_o),
    .cmd_done_o(cmd_done_o), .cmd_byte_o(cmd_byte_o), .diag_clear_o(diag_clear_o));

  sdr_host_model sdr_host_model_inst (
    .clk_sys_i(clk_sys_i), .miso_i(miso_o), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  // 50 MHz system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Pulse counters and the hang guard; the ceiling is several times the planned run.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cmd_done_o === 1'b1) done_cnt++;
    if (diag_clear_o === 1'b1) clr_cnt++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // Interleaves two per-channel flag sets, b2 pair on top, upper flag first.
  function automatic logic [7:0] ilv(input logic [3:0] u, input logic [3:0] l);
    logic [7:0] r;
    for (int k = 0; k < 4; k++) begin
      r[2*k+1] = u[k];
      r[2*k]   = l[k];
    end
    return r;
  endfunction : ilv

  // Expected answer byte of a command given the status seen at its frame end.
  function automatic logic [7:0] exp_resp(input logic [7:0] c, input sdr_diag_t d);
    if (c >= 8'hA0 && c <= 8'hA2 || c[7:4] == 4'h5) return c;
    case (c)
      8'h70, 8'h71, 8'h72, 8'h73: return cnt_exp[c[1:0]];
      8'h79: return {4'h0, d.cur_limit};
      8'h7F: return ilv(d.low_side_thermal_flag, d.high_side_thermal_flag);
      8'hC0: return {d.safing_res_low_flag[1], d.safing_res_high_flag[1], d.diag_supply_high_flag[1],
                     d.diag_supply_low_flag[1], d.safing_res_low_flag[0], d.safing_res_high_flag[0],
                     d.diag_supply_high_flag[0], d.diag_supply_low_flag[0]};
      8'hC1: return ilv(d.no_short_ground_flag, d.no_short_battery_flag);
      8'hC2: return {4'h0, d.low_side_continuity_flag};
      8'hC3: return ilv(d.open_no_short_ground_flag, d.open_no_short_battery_flag);
      8'hC5: return {3'b000, d.fire_supply_b_tested, 2'b00, d.fire_supply_high_flag, d.fire_supply_low_flag};
      8'hC6: return {d.diag_supply2_level, d.diag_supply1_level};
      default: return 8'h00;
    endcase
  endfunction : exp_resp

  // One full command: checks the previous answer, completion and command capture.
  task automatic do_cmd(input logic [7:0] code);
    logic [7:0]  resp;
    logic [63:0] rv;
    int          d0;
    d0 = done_cnt;
    sdr_host_model_inst.xfer(code, 8, resp);
    `CHK("answer byte", prev_exp, resp)
    prev_exp = exp_resp(code, diag_i);
    repeat (3) @(posedge clk_sys_i);
    `CHK("done pulses", d0 + 1, done_cnt)
    `CHK("command byte", code, cmd_byte_o)
    rv = {$urandom, $urandom};
    diag_i <= rv[$bits(sdr_diag_t)-1:0];
  endtask : do_cmd

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence: table sweep, random commands, short frame, saturation, arming clear.
  initial begin
    logic [7:0] r;
    int         d0;
    rst_n_i = 1'b0;
    diag_i = '0;
    meas_run_i = 4'h0;
    cur_above_i = 4'h0;
    prev_exp = 8'h00;
    for (int i = 0; i < 4; i++) cnt_exp[i] = 8'h00;
    seed = $urandom(32'h104fc1ce);
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 48; i++) do_cmd(i < 16 ? codes[i] : codes[$urandom % 16]);
    // A truncated frame is dropped; the stored answer must survive it.
    d0 = done_cnt;
    sdr_host_model_inst.xfer(8'hC1, 5, r);
    repeat (3) @(posedge clk_sys_i);
    `CHK("short frame", d0, done_cnt)
    do_cmd(8'h00);
    // counts saturate only where current is above threshold
    @(posedge clk_sys_i);
    meas_run_i <= 4'hF;
    cur_above_i <= 4'(($urandom & 4'h7) | 4'h3);
    repeat (1100) @(posedge clk_sys_i);
    meas_run_i <= 4'h0;
    for (int i = 0; i < 4; i++) cnt_exp[i] = cur_above_i[i] ? 8'hFF : 8'h00;
    for (int i = 0; i < 4; i++) do_cmd(8'h70 + 8'(i));
    d0 = clr_cnt;
    do_cmd(8'hA2);
    `CHK("clear pulses", d0 + 1, clr_cnt)
    for (int i = 0; i < 4; i++) cnt_exp[i] = 8'h00;
    do_cmd(8'h70);
    do_cmd(8'h73);
    do_cmd(8'h00);
    report_and_stop();
  end
endmodule : tb
